// [design/sic_client.sv]
// Two-wire byte-access client with auto-incrementing register pointer.
`timescale 1ns/1ns
module sic_client
   import sic_pkg::*;
#(
   parameter int LOW_CYC  = SIC_LOW_CYC,
   parameter int IDLE_CYC = SIC_IDLE_CYC
) (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       serial_clock_pin_i,
   output logic            serial_clock_pin_o,
   output logic            serial_clock_pin_oe,
   input  wire logic       serial_data_pin_i,
   output logic            serial_data_pin_o,
   output logic            serial_data_pin_oe,
   input  wire logic [2:0] protocol_address_strap_pin,
   input  wire logic       deep_sleep_flag,
   input  wire logic       timeout_en,
   output logic [7:0]      reg_addr,
   input  wire logic [7:0] reg_rd_data,
   output sic_wr_t         reg_wr,
   output logic            client_active
);

   sic_st_t q;
   sic_st_t n;
   logic    to_fire;
   logic    scl_rise;
   logic    scl_fall;
   logic    start_det;
   logic    stop_det;
   logic    at_end;
   logic    addr_ok;

   // ==========================================================
   // Line events
   assign scl_rise  = q.scl_s && !q.scl_p;
   assign scl_fall  = !q.scl_s && q.scl_p;
   assign start_det = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
   assign stop_det  = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;
   assign at_end    = scl_fall && (q.bit_cnt == SIC_BITS);

   // Read without a register byte in this frame is Receive Byte
   assign addr_ok = q.i2c_on && (q.shift[7:1] == q.my_addr)
                    && !(q.shift[0] && !q.got_reg && deep_sleep_flag);

   sic_timeout #(
      .LOW_CYC  (LOW_CYC),
      .IDLE_CYC (IDLE_CYC)
   ) u_timeout (
      .clk     (clk),
      .sys_rst (sys_rst),
      .enable  (timeout_en),
      .scl     (q.scl_s),
      .sda     (q.sda_s),
      .expire  (to_fire)
   );

   // ==========================================================
   // Next state
   always_comb begin
      n = q;
      n.scl_m   = serial_clock_pin_i;
      n.scl_s   = q.scl_m;
      n.scl_p   = q.scl_s;
      n.sda_m   = serial_data_pin_i;
      n.sda_s   = q.sda_m;
      n.sda_p   = q.sda_s;
      n.strap_m = protocol_address_strap_pin;
      n.strap_s = q.strap_m;
      n.wr.vld  = 1'b0;

      // Strap is caught once, after the synchroniser has settled
      if (!q.strap_done) begin
         n.cap_cnt = q.cap_cnt + SIC_CAP_STEP;
         if (q.cap_cnt == SIC_STRAP_WAIT) begin
            n.strap_done            = 1'b1;
            {n.i2c_on, n.my_addr}   = sic_strap_decode(q.strap_s);
         end
      end

      if (stop_det || to_fire) begin
         n.fsm     = SIC_IDLE;
         n.sda_oe  = 1'b0;
         n.got_reg = 1'b0;
         n.sb      = 1'b0;
         if (q.sb) begin
            n.ptr = q.ptr_save;
         end
      end else if (start_det) begin
         n.fsm     = SIC_ADDR;
         n.bit_cnt = '0;
         n.sda_oe  = 1'b0;
         n.sb      = 1'b0;
         if (q.fsm == SIC_IDLE) begin
            n.got_reg = 1'b0;
         end
      end else if (scl_rise) begin
         case (q.fsm)
            SIC_ADDR, SIC_REG, SIC_WDATA: begin
               n.shift   = {q.shift[6:0], q.sda_s};
               n.bit_cnt = q.bit_cnt + SIC_BIT_STEP;
            end
            SIC_RDATA: begin
               n.bit_cnt = q.bit_cnt + SIC_BIT_STEP;
            end
            SIC_RDATA_ACK: begin
               n.ack = !q.sda_s;
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (q.fsm)
            SIC_ADDR: begin
               if (at_end) begin
                  if (addr_ok) begin
                     n.fsm    = SIC_ADDR_ACK;
                     n.sda_oe = 1'b1;
                     n.rw     = q.shift[0];
                  end else begin
                     n.fsm = SIC_IGNORE;
                  end
               end
            end
            SIC_ADDR_ACK: begin
               n.bit_cnt = '0;
               if (q.rw) begin
                  n.fsm    = SIC_RDATA;
                  n.shift  = reg_rd_data;
                  n.sda_oe = !reg_rd_data[7];
               end else begin
                  n.fsm    = SIC_REG;
                  n.sda_oe = 1'b0;
               end
            end
            SIC_REG: begin
               if (at_end) begin
                  n.fsm     = SIC_REG_ACK;
                  n.sda_oe  = 1'b1;
                  n.ptr     = q.shift;
                  n.got_reg = 1'b1;
                  if (deep_sleep_flag) begin
                     n.sb       = 1'b1;
                     n.ptr_save = q.ptr;
                  end
               end
            end
            SIC_REG_ACK, SIC_WDATA_ACK: begin
               n.fsm     = SIC_WDATA;
               n.bit_cnt = '0;
               n.sda_oe  = 1'b0;
            end
            SIC_WDATA: begin
               if (at_end) begin
                  n.fsm     = SIC_WDATA_ACK;
                  n.sda_oe  = 1'b1;
                  n.wr.vld  = 1'b1;
                  n.wr.addr = q.ptr;
                  n.wr.data = q.shift;
                  n.ptr     = q.ptr + SIC_PTR_STEP;
                  n.sb      = 1'b0;
               end
            end
            SIC_RDATA: begin
               if (at_end) begin
                  n.fsm    = SIC_RDATA_ACK;
                  n.sda_oe = 1'b0;
                  if (q.got_reg) begin
                     n.ptr = q.ptr + SIC_PTR_STEP;
                  end
               end else begin
                  n.shift  = {q.shift[6:0], 1'b0};
                  n.sda_oe = !q.shift[6];
               end
            end
            SIC_RDATA_ACK: begin
               if (q.ack) begin
                  n.fsm     = SIC_RDATA;
                  n.bit_cnt = '0;
                  n.shift   = reg_rd_data;
                  n.sda_oe  = !reg_rd_data[7];
               end else begin
                  n.fsm = SIC_IGNORE;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= SIC_ST_RST;
      end else begin
         q <= n;
      end
   end

   // ==========================================================
   // Outputs
   // Clock line is input only, so the host may stretch at will while timeout_en is low
   assign serial_clock_pin_o  = 1'b0;
   assign serial_clock_pin_oe = 1'b0;
   assign serial_data_pin_o   = 1'b0;
   assign serial_data_pin_oe  = q.sda_oe;
   assign reg_addr            = q.ptr;
   assign reg_wr              = q.wr;
   assign client_active       = (q.fsm != SIC_IDLE) && (q.fsm != SIC_IGNORE);

   // ==========================================================
   // Checks
   sequence s_addr_end;
      q.fsm == SIC_ADDR && at_end && !stop_det && !start_det && !to_fire;
   endsequence

   sequence s_wbyte_end;
      q.fsm == SIC_WDATA && at_end && !stop_det && !start_det && !to_fire;
   endsequence

   sequence s_rbyte_end;
      q.fsm == SIC_RDATA && at_end && !stop_det && !start_det && !to_fire;
   endsequence

   property p_no_stretch;
      @(posedge clk) disable iff (sys_rst)
      !serial_clock_pin_oe;
   endproperty
   a_no_stretch: assert property (p_no_stretch)
      else $error("clock line driven");

   property p_start;
      @(posedge clk) disable iff (sys_rst)
      (start_det && !stop_det && !to_fire)
         |=> (q.fsm == SIC_ADDR) && (q.bit_cnt == '0) && !q.sda_oe;
   endproperty
   a_start: assert property (p_start)
      else $error("start not taken");

   property p_addr_ack;
      @(posedge clk) disable iff (sys_rst)
      (s_addr_end and addr_ok) |=> serial_data_pin_oe
         && q.rw == $past(q.shift[0]);
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("matching address not acknowledged");

   property p_ignore;
      @(posedge clk) disable iff (sys_rst)
      (q.fsm == SIC_IGNORE) |-> !serial_data_pin_oe;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("data driven while ignoring");

   property p_stop;
      @(posedge clk) disable iff (sys_rst)
      stop_det |=> (q.fsm == SIC_IDLE) && !serial_data_pin_oe;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop did not reset client");

   property p_write_store;
      @(posedge clk) disable iff (sys_rst)
      s_wbyte_end |=> reg_wr.vld && serial_data_pin_oe
         && reg_wr.data == $past(q.shift) ##1 !reg_wr.vld;
   endproperty
   a_write_store: assert property (p_write_store)
      else $error("received byte not stored and acknowledged");

   property p_write_wrap;
      @(posedge clk) disable iff (sys_rst)
      reg_wr.vld |-> q.ptr == reg_wr.addr + SIC_PTR_STEP;
   endproperty
   a_write_wrap: assert property (p_write_wrap)
      else $error("pointer not advanced after write");

   property p_read_inc;
      @(posedge clk) disable iff (sys_rst)
      (s_rbyte_end and q.got_reg) |=> q.ptr == $past(q.ptr) + SIC_PTR_STEP;
   endproperty
   a_read_inc: assert property (p_read_inc)
      else $error("pointer not advanced after read");

   property p_recv_hold;
      @(posedge clk) disable iff (sys_rst)
      (s_rbyte_end and !q.got_reg) |=> $stable(q.ptr);
   endproperty
   a_recv_hold: assert property (p_recv_hold)
      else $error("receive byte moved the pointer");

   property p_sleep_recv;
      @(posedge clk) disable iff (sys_rst)
      (s_addr_end and q.shift[0] && !q.got_reg && deep_sleep_flag)
         |=> q.fsm == SIC_IGNORE;
   endproperty
   a_sleep_recv: assert property (p_sleep_recv)
      else $error("receive byte serviced in deep sleep");

   property p_msb_first;
      @(posedge clk) disable iff (sys_rst)
      (q.fsm == SIC_RDATA && $past(q.fsm) != SIC_RDATA)
         |-> serial_data_pin_oe == !$past(reg_rd_data[7]);
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("first read bit is not the top bit");

endmodule : sic_client

// [design/sic_pkg.sv]
// Constants, types and decode helpers shared by the two-wire client.
package sic_pkg;

   // ==========================================================
   // Timing
   localparam int SIC_CLK_HZ    = 50_000_000;
   localparam int SIC_T_LOW_MS  = 30;
   localparam int SIC_T_IDLE_US = 200;
   localparam int SIC_LOW_CYC   = SIC_CLK_HZ / 1000 * SIC_T_LOW_MS;
   localparam int SIC_IDLE_CYC  = SIC_CLK_HZ / 1_000_000 * SIC_T_IDLE_US;
   localparam int SIC_LOW_W     = $clog2(SIC_LOW_CYC + 1);
   localparam int SIC_IDLE_W    = $clog2(SIC_IDLE_CYC + 1);

   // ==========================================================
   // Framing and strap decode
   localparam logic [3:0] SIC_BITS         = 4'h8;
   localparam logic [3:0] SIC_BIT_STEP     = 4'h1;
   localparam logic [7:0] SIC_PTR_STEP     = 8'h01;
   localparam logic [1:0] SIC_STRAP_WAIT   = 2'h3;
   localparam logic [1:0] SIC_CAP_STEP     = 2'h1;
   localparam logic [2:0] SIC_STRAP_I2C_LO = 3'h3;
   localparam logic [6:0] SIC_ADDR_TOP     = 7'h2c;

   typedef enum logic [3:0] {
      SIC_IDLE      = 4'h0,
      SIC_ADDR      = 4'h1,
      SIC_ADDR_ACK  = 4'h3,
      SIC_REG       = 4'h2,
      SIC_REG_ACK   = 4'h6,
      SIC_WDATA     = 4'h7,
      SIC_WDATA_ACK = 4'h5,
      SIC_RDATA     = 4'h4,
      SIC_RDATA_ACK = 4'hc,
      SIC_IGNORE    = 4'hd
   } sic_fsm_t;

   typedef struct packed {
      logic       vld;
      logic [7:0] addr;
      logic [7:0] data;
   } sic_wr_t;

   typedef struct packed {
      logic       scl_m;
      logic       scl_s;
      logic       scl_p;
      logic       sda_m;
      logic       sda_s;
      logic       sda_p;
      logic [2:0] strap_m;
      logic [2:0] strap_s;
      logic [1:0] cap_cnt;
      logic       strap_done;
      logic       i2c_on;
      logic [6:0] my_addr;
      sic_fsm_t   fsm;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic [7:0] ptr;
      logic [7:0] ptr_save;
      logic       rw;
      logic       got_reg;
      logic       sb;
      logic       ack;
      logic       sda_oe;
      sic_wr_t    wr;
   } sic_st_t;

   typedef struct packed {
      logic [SIC_LOW_W-1:0]  low_cnt;
      logic [SIC_IDLE_W-1:0] idle_cnt;
      logic                  fire;
   } sic_to_st_t;

   localparam sic_st_t    SIC_ST_RST = '0;
   localparam sic_to_st_t SIC_TO_RST = '0;

   // Strap code to {two-wire enable, 7-bit address}
   function automatic logic [7:0] sic_strap_decode(input logic [2:0] code);
      logic [2:0] ofs;
      ofs = code - SIC_STRAP_I2C_LO;
      if (code < SIC_STRAP_I2C_LO) begin
         return 8'h00;
      end
      return {1'b1, SIC_ADDR_TOP - {4'h0, ofs}};
   endfunction : sic_strap_decode

endpackage : sic_pkg

// [design/sic_timeout.sv]
// Clock-low and bus-idle watchdog for the two-wire client.
`timescale 1ns/1ns
module sic_timeout
   import sic_pkg::*;
#(
   parameter int LOW_CYC  = SIC_LOW_CYC,
   parameter int IDLE_CYC = SIC_IDLE_CYC
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic enable,
   input  wire logic scl,
   input  wire logic sda,
   output logic      expire
);

   localparam logic [SIC_LOW_W-1:0]  LOW_LIM  = SIC_LOW_W'(LOW_CYC);
   localparam logic [SIC_LOW_W-1:0]  LOW_END  = SIC_LOW_W'(LOW_CYC - 1);
   localparam logic [SIC_IDLE_W-1:0] IDLE_LIM = SIC_IDLE_W'(IDLE_CYC);
   localparam logic [SIC_IDLE_W-1:0] IDLE_END = SIC_IDLE_W'(IDLE_CYC - 1);

   sic_to_st_t q;
   sic_to_st_t n;

   // ==========================================================
   // Counters
   // Counters saturate so that one stuck bus gives one pulse only.
   always_comb begin
      n = q;
      n.fire = 1'b0;
      if (!enable || scl) begin
         n.low_cnt = '0;
      end else if (q.low_cnt != LOW_LIM) begin
         n.low_cnt = q.low_cnt + {{(SIC_LOW_W-1){1'b0}}, 1'b1};
         if (q.low_cnt == LOW_END) begin
            n.fire = 1'b1;
         end
      end
      if (!enable || !(scl && sda)) begin
         n.idle_cnt = '0;
      end else if (q.idle_cnt != IDLE_LIM) begin
         n.idle_cnt = q.idle_cnt + {{(SIC_IDLE_W-1){1'b0}}, 1'b1};
         if (q.idle_cnt == IDLE_END) begin
            n.fire = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= SIC_TO_RST;
      end else begin
         q <= n;
      end
   end

   assign expire = q.fire;

   // ==========================================================
   // Checks
   property p_low_fire;
      @(posedge clk) disable iff (sys_rst)
      (enable && !scl && q.low_cnt == LOW_END) |=> expire;
   endproperty
   a_low_fire: assert property (p_low_fire)
      else $error("clock-low timeout did not fire");

   property p_idle_fire;
      @(posedge clk) disable iff (sys_rst)
      (enable && scl && sda && q.idle_cnt == IDLE_END) |=> expire;
   endproperty
   a_idle_fire: assert property (p_idle_fire)
      else $error("bus-idle timeout did not fire");

   property p_off;
      @(posedge clk) disable iff (sys_rst)
      !enable |=> !expire;
   endproperty
   a_off: assert property (p_off)
      else $error("timeout fired while disabled");

endmodule : sic_timeout

// [tb/sic_host_model.sv]
// Behavioural two-wire host that drives the client's link.
`timescale 1ns/1ns
module sic_host_model (
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   // ==========================================================
   // Line primitives, 160 ns bit period, clock idles high
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // Steps land on rising clock edges, so lines move by NBA
   // Also serves as repeated start from a low clock
   task automatic start();
      sda_pull <= 1'b0;
      #40 scl <= 1'b1;
      #80 sda_pull <= 1'b1;
      #80 scl <= 1'b0;
      #40;
   endtask : start

   task automatic stop();
      sda_pull <= 1'b1;
      #40 scl <= 1'b1;
      #80 sda_pull <= 1'b0;
      #80;
   endtask : stop

   // Lets both lines float high mid-frame, no start or stop
   task automatic float_high();
      sda_pull <= 1'b0;
      #40 scl <= 1'b1;
   endtask : float_high

   // Bit period 160 ns, well inside the legal clock range
   task automatic clk_bit(input logic pull, output logic seen);
      sda_pull <= pull;
      #40 scl <= 1'b1;
      #80 seen = sda;
      scl <= 1'b0;
      #40;
   endtask : clk_bit

   task automatic put_byte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(!v[i], s);
      end
      clk_bit(1'b0, s);
      ack = !s;
   endtask : put_byte

   // No count byte is ever sent or expected
   task automatic get_byte(input logic ack, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b0, s);
         v[i] = s;
      end
      clk_bit(ack, s);
   endtask : get_byte

endmodule : sic_host_model

// [tb/tb_top.sv]
// Self-checking bench for the two-wire register client.
`timescale 1ns/1ns
module tb_top;
   import sic_pkg::*;

   localparam logic [6:0] DEV = 7'h2c;

   logic       clk, sys_rst, ds_flag, to_en, scl, h_pull, sda;
   logic       scl_o, scl_oe, sda_o, sda_oe, act, ack;
   logic [2:0] strap;
   logic [7:0] reg_addr, rd_data, b;
   sic_wr_t    reg_wr;
   logic [7:0] regs [256];
   int         err_total, comparisons, wr_cnt, oe_cnt, scl_oe_cnt;

   // Open-drain line with pull-up
   assign sda = !(h_pull || (sda_oe && !sda_o));
   assign rd_data = regs[reg_addr];

   sic_client #(.LOW_CYC(400), .IDLE_CYC(200)) dut (
      .clk                        (clk),
      .sys_rst                    (sys_rst),
      .serial_clock_pin_i         (scl),
      .serial_clock_pin_o         (scl_o),
      .serial_clock_pin_oe        (scl_oe),
      .serial_data_pin_i          (sda),
      .serial_data_pin_o          (sda_o),
      .serial_data_pin_oe         (sda_oe),
      .protocol_address_strap_pin (strap),
      .deep_sleep_flag            (ds_flag),
      .timeout_en                 (to_en),
      .reg_addr                   (reg_addr),
      .reg_rd_data                (rd_data),
      .reg_wr                     (reg_wr),
      .client_active              (act)
   );

   sic_host_model host (.scl(scl), .sda_pull(h_pull), .sda(sda));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ==========================================================
   // Register file and line monitors
   always @(posedge clk) begin
      if (reg_wr.vld === 1'b1) begin
         regs[reg_wr.addr] <= reg_wr.data;
         wr_cnt++;
      end
      if (sda_oe === 1'b1) oe_cnt++;
      if (scl_oe !== 1'b0) scl_oe_cnt++;
   end

   // ==========================================================
   // Compare and bus helpers
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask : chk

   task automatic tx(input logic [7:0] v, input logic e, input string w);
      host.put_byte(v, ack);
      chk(w, {7'h00, e}, {7'h00, ack});
   endtask : tx

   task automatic hdr(input logic [7:0] r);
      host.start();
      tx({DEV, 1'b0}, 1'b1, "addr w ack");
      tx(r, 1'b1, "reg ack");
   endtask : hdr

   task automatic raddr(input logic e);
      host.start();
      tx({DEV, 1'b1}, e, "addr r ack");
   endtask : raddr

   task automatic rdb(input logic hack, input logic [7:0] e, input string w);
      host.get_byte(hack, b);
      chk(w, e, b);
   endtask : rdb

   // ==========================================================
   // Scenarios
   task automatic t_write_read();
      hdr(8'h10);
      tx(8'ha5, 1'b1, "data ack");
      host.stop();
      chk("stored", 8'ha5, regs[8'h10]);
      chk("idle after stop", 8'h00, {7'h00, act});
      hdr(8'h10);
      raddr(1'b1);
      rdb(1'b0, 8'ha5, "read byte");
      host.stop();
      $display("test write_read done");
   endtask : t_write_read

   task automatic t_block();
      hdr(8'hfe);
      tx(8'h11, 1'b1, "bw0 ack");
      tx(8'h22, 1'b1, "bw1 ack");
      tx(8'h33, 1'b1, "bw2 ack");
      host.stop();
      chk("reg fe", 8'h11, regs[8'hfe]);
      chk("reg ff", 8'h22, regs[8'hff]);
      chk("reg 00", 8'h33, regs[8'h00]);
      hdr(8'hfe);
      raddr(1'b1);
      rdb(1'b1, 8'h11, "br0");
      rdb(1'b1, 8'h22, "br1");
      rdb(1'b0, 8'h33, "br2");
      host.stop();
      $display("test block done");
   endtask : t_block

   task automatic t_send_recv();
      int w0;
      w0 = wr_cnt;
      hdr(8'h40);
      host.stop();
      chk("send writes", w0[7:0], wr_cnt[7:0]);
      for (int k = 0; k < 2; k++) begin
         raddr(1'b1);
         rdb(1'b1, 8'h1a, "recv first");
         rdb(1'b0, 8'h1a, "recv again");
         host.stop();
      end
      $display("test send_recv done");
   endtask : t_send_recv

   task automatic t_sleep();
      @(posedge clk) ds_flag <= 1'b1;
      hdr(8'h50);
      host.stop();
      raddr(1'b0);
      host.stop();
      @(posedge clk) ds_flag <= 1'b0;
      raddr(1'b1);
      rdb(1'b0, 8'h1a, "pointer kept");
      host.stop();
      $display("test sleep done");
   endtask : t_sleep

   task automatic t_mismatch();
      int o0, w0;
      o0 = oe_cnt;
      w0 = wr_cnt;
      host.start();
      tx({7'h50, 1'b0}, 1'b0, "foreign addr");
      tx(8'h10, 1'b0, "foreign reg");
      tx(8'h99, 1'b0, "foreign data");
      host.stop();
      chk("foreign oe", o0[7:0], oe_cnt[7:0]);
      chk("foreign writes", w0[7:0], wr_cnt[7:0]);
      $display("test mismatch done");
   endtask : t_mismatch

   task automatic t_timeout();
      // Disabled after reset: a long low is plain host stretching
      hdr(8'h70);
      #10000;
      tx(8'h77, 1'b1, "ack after stretch");
      host.stop();
      chk("stretched write", 8'h77, regs[8'h70]);
      @(posedge clk) to_en <= 1'b1;
      hdr(8'h71);
      #10000;
      chk("low expiry", 8'h00, {7'h00, act});
      tx(8'h78, 1'b0, "ack after expiry");
      host.stop();
      chk("no write", 8'h2b, regs[8'h71]);
      hdr(8'h72);
      host.float_high();
      chk("active before idle", 8'h01, {7'h00, act});
      #6000;
      chk("idle expiry", 8'h00, {7'h00, act});
      host.start();
      host.stop();
      @(posedge clk) to_en <= 1'b0;
      $display("test timeout done");
   endtask : t_timeout

   // ==========================================================
   // Run control
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   initial begin
      #1000000;
      err_total++;
      final_report();
   end

   initial begin
      sys_rst = 1'b1;
      strap = 3'h3;
      ds_flag = 1'b0;
      to_en = 1'b0;
      for (int i = 0; i < 256; i++) begin
         regs[i] = i[7:0] ^ 8'h5a;
      end
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (10) @(posedge clk);
      t_write_read();
      t_block();
      t_send_recv();
      t_sleep();
      t_mismatch();
      t_timeout();
      chk("clock pulls", 8'h00, scl_oe_cnt[7:0]);
      final_report();
   end

endmodule : tb_top
